//--- rtsa_cfg.svh
/*
 Constants for the transmit subaddress control word block: register
 offsets, field positions, reset values and mode codes.
 Assumes inclusion by its bare name from the package and the modules.
*/
`ifndef RTSA_CFG_SVH
`define RTSA_CFG_SVH

`define RTSA_ADDR_W 4
`define RTSA_OFS_CTRL 4'h0
`define RTSA_OFS_GLOBAL 4'h4
`define RTSA_OFS_EXTCFG 4'h8
`define RTSA_OFS_IRQ_STAT 4'hC

`define RTSA_BIT_FORCE_BUSY 12
`define RTSA_BIT_ACCESSED 11
`define RTSA_BIT_NEXT_BUF 10
`define RTSA_BIT_MODE_LO 0
`define RTSA_BIT_MODE_HI 1
`define RTSA_BIT_GLOBAL_BUSY 0
`define RTSA_BIT_HOLD_SEL 0
`define RTSA_BIT_IRQ_MASK_LO 8

`define RTSA_IRQ_W 3
`define RTSA_IRQ_DONE 0
`define RTSA_IRQ_OK 1
`define RTSA_IRQ_FAIL 2

`define RTSA_MODE_PINGPONG 2'h0
`define RTSA_MODE_INDEXED 2'h1
`define RTSA_MODE_CIRC1 2'h2
`define RTSA_MODE_CIRC2 2'h3

`define RTSA_CTRL_RESET 16'h0000
`define RTSA_ZERO32 32'h00000000
`define RTSA_UNMAPPED 32'hDEADBEEF

`endif

//--- rtsa_pkg.sv
/*
 Types shared by the transmit subaddress control word block.
 Assumes rtsa_cfg.svh is reachable on the include path.
*/
`include "rtsa_cfg.svh"

package rtsa_pkg;

    typedef struct packed {
        logic done;
        logic ok;
        logic busy;
        logic fail;
    } rtsa_msg_type;

    typedef enum logic [1:0] {
        RTSA_IDLE = 2'b00,
        RTSA_RESP = 2'b01
    } rtsa_state_type;

endpackage : rtsa_pkg

//--- rtsa_selector.sv
/*
 Next-buffer selector and accessed flag of one transmit subaddress.
 Assumes message completion events arrive as one-cycle pulses on SYS_CLK.
*/
`timescale 1ns/1ps
`include "rtsa_cfg.svh"

module rtsa_selector
    import rtsa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    // Events
    input wire rtsa_msg_type msg,
    input wire logic ctrl_read,
    input wire logic [1:0] mode,
    input wire logic hold_sel,
    // State
    output logic accessed,
    output logic next_buf
);

    logic accessed_ff;
    logic nxt_accessed;
    logic next_buf_ff;
    logic nxt_next_buf;
    logic pingpong;

    assign pingpong = (mode == `RTSA_MODE_PINGPONG);

    always_comb
    begin
        nxt_accessed = accessed_ff;
        if (ctrl_read)
        begin
            nxt_accessed = 1'b0;
        end
        // Set wins over a clearing read in the same cycle
        if (msg.done)
        begin
            nxt_accessed = 1'b1;
        end
        if (soft_rst)
        begin
            nxt_accessed = 1'b0;
        end
    end

    always_comb
    begin
        nxt_next_buf = next_buf_ff;
        // Busy never toggles; failures toggle only without the hold bit
        if (msg.done && pingpong && !msg.busy)
        begin
            if (msg.ok || (msg.fail && !hold_sel))
            begin
                nxt_next_buf = ~next_buf_ff;
            end
        end
        if (soft_rst)
        begin
            nxt_next_buf = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            accessed_ff <= 1'b0;
            next_buf_ff <= 1'b0;
        end
        else
        begin
            accessed_ff <= nxt_accessed;
            next_buf_ff <= nxt_next_buf;
        end
    end

    assign accessed = accessed_ff;
    assign next_buf = next_buf_ff;

endmodule : rtsa_selector

//--- rtsa_ctrl_word.sv
/*
 Transmit subaddress control word: force-busy, accessed flag and
 ping-pong next-buffer selector, with an Avalon-MM register slave.
 Assumes the bus controller side is logic on SYS_CLK giving one-cycle
 pulses; RESETN is the master reset.
*/
// Functional notes
// - Per-subaddress busy bit forces Busy answer
// - Global busy or local busy both apply
// - Busy: no data, selector unchanged
// - Message completion sets accessed flag
// - Resets or control word read clear flag
// - Selector picks pointer A or B
// - Ping-pong: invert selector after good message
// - Resets clear selector to zero
// - Other buffer modes ignore selector
`timescale 1ns/1ps
`include "rtsa_cfg.svh"

module rtsa_ctrl_word
    import rtsa_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Avalon-MM slave
    input wire logic [`RTSA_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Reset command
    input wire logic SOFT_RESET_COMMAND,
    // Bus controller side
    input wire logic TX_CMD_VALID,
    input wire logic MSG_DONE,
    input wire logic MSG_ERROR,
    output logic RESP_VALID,
    output logic RESP_BUSY,
    output logic RESP_SEND_DATA,
    output logic RESP_USE_PTR_B,
    // Interrupt
    output logic IRQ
);

    logic [15:0] ctrl_ff;
    logic [15:0] nxt_ctrl;
    logic global_busy_ff;
    logic nxt_global_busy;
    logic hold_sel_ff;
    logic nxt_hold_sel;
    logic [`RTSA_IRQ_W-1:0] irq_stat_ff;
    logic [`RTSA_IRQ_W-1:0] nxt_irq_stat;
    logic [`RTSA_IRQ_W-1:0] irq_mask_ff;
    logic [`RTSA_IRQ_W-1:0] nxt_irq_mask;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic ack_ff;
    logic nxt_ack;
    rtsa_state_type state_ff;
    rtsa_state_type nxt_state;
    logic resp_busy_ff;
    logic nxt_resp_busy;
    logic busy_ff;
    logic nxt_busy;
    logic use_b_ff;
    logic nxt_use_b;
    logic accessed;
    logic next_buf;
    logic ctrl_read;
    logic wr_take;
    logic rd_take;
    logic busy_now;
    logic [1:0] mode;
    rtsa_msg_type msg;

    function automatic logic [15:0] merge_bytes(input logic [15:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge_bytes

    function automatic logic hit(input logic [`RTSA_ADDR_W-1:0] a,
                                 input logic [`RTSA_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : hit

    // One wait cycle per access: request taken on the edge where ack is set
    assign wr_take = AVS_WRITE && !ack_ff;
    assign rd_take = AVS_READ && !ack_ff;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_ff;
    assign AVS_READDATA = rdata_ff;
    assign ctrl_read = rd_take && hit(AVS_ADDRESS, `RTSA_OFS_CTRL);

    assign mode = ctrl_ff[`RTSA_BIT_MODE_HI:`RTSA_BIT_MODE_LO];

    // Either busy source applies; the local bit only covers this subaddress
    assign busy_now = ctrl_ff[`RTSA_BIT_FORCE_BUSY] || global_busy_ff;

    assign msg.done = MSG_DONE;
    assign msg.busy = busy_ff;
    assign msg.ok = MSG_DONE && !MSG_ERROR && !busy_ff;
    assign msg.fail = MSG_DONE && MSG_ERROR;

    rtsa_selector u_selector (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .soft_rst(SOFT_RESET_COMMAND),
        .msg(msg),
        .ctrl_read(ctrl_read),
        .mode(mode),
        .hold_sel(hold_sel_ff),
        .accessed(accessed),
        .next_buf(next_buf)
    );

    // Register bank
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_global_busy = global_busy_ff;
        nxt_hold_sel = hold_sel_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = (AVS_READ || AVS_WRITE) && !ack_ff;
        if (wr_take)
        begin
            case (AVS_ADDRESS)
                `RTSA_OFS_CTRL:
                begin
                    nxt_ctrl = merge_bytes(ctrl_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
                end
                `RTSA_OFS_GLOBAL:
                begin
                    if (AVS_BYTEENABLE[0])
                    begin
                        nxt_global_busy = AVS_WRITEDATA[`RTSA_BIT_GLOBAL_BUSY];
                    end
                end
                `RTSA_OFS_EXTCFG:
                begin
                    if (AVS_BYTEENABLE[0])
                    begin
                        nxt_hold_sel = AVS_WRITEDATA[`RTSA_BIT_HOLD_SEL];
                    end
                end
                `RTSA_OFS_IRQ_STAT:
                begin
                    if (AVS_BYTEENABLE[0])
                    begin
                        nxt_irq_stat = irq_stat_ff & ~AVS_WRITEDATA[`RTSA_IRQ_W-1:0];
                    end
                    if (AVS_BYTEENABLE[1])
                    begin
                        nxt_irq_mask = AVS_WRITEDATA[`RTSA_BIT_IRQ_MASK_LO +: `RTSA_IRQ_W];
                    end
                end
                default:
                begin
                    nxt_ctrl = ctrl_ff;
                end
            endcase
        end
        // Accessed and selector bits are device-owned, never stored here
        nxt_ctrl[`RTSA_BIT_ACCESSED] = 1'b0;
        nxt_ctrl[`RTSA_BIT_NEXT_BUF] = 1'b0;
        // Events set after the clear so a same-cycle event is kept
        if (msg.done)
        begin
            nxt_irq_stat[`RTSA_IRQ_DONE] = 1'b1;
        end
        if (msg.ok)
        begin
            nxt_irq_stat[`RTSA_IRQ_OK] = 1'b1;
        end
        if (msg.fail)
        begin
            nxt_irq_stat[`RTSA_IRQ_FAIL] = 1'b1;
        end
        if (rd_take)
        begin
            nxt_rdata = `RTSA_ZERO32;
            case (AVS_ADDRESS)
                `RTSA_OFS_CTRL:
                begin
                    nxt_rdata[15:0] = ctrl_ff;
                    nxt_rdata[`RTSA_BIT_ACCESSED] = accessed;
                    nxt_rdata[`RTSA_BIT_NEXT_BUF] = next_buf;
                end
                `RTSA_OFS_GLOBAL:
                begin
                    nxt_rdata[`RTSA_BIT_GLOBAL_BUSY] = global_busy_ff;
                end
                `RTSA_OFS_EXTCFG:
                begin
                    nxt_rdata[`RTSA_BIT_HOLD_SEL] = hold_sel_ff;
                end
                `RTSA_OFS_IRQ_STAT:
                begin
                    nxt_rdata[`RTSA_IRQ_W-1:0] = irq_stat_ff;
                    nxt_rdata[`RTSA_BIT_IRQ_MASK_LO +: `RTSA_IRQ_W] = irq_mask_ff;
                end
                default:
                begin
                    nxt_rdata = `RTSA_UNMAPPED;
                end
            endcase
        end
        // Soft reset clears device-held status only; host settings survive
        if (SOFT_RESET_COMMAND)
        begin
            nxt_irq_stat = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_ff <= `RTSA_CTRL_RESET;
            global_busy_ff <= 1'b0;
            hold_sel_ff <= 1'b0;
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            rdata_ff <= `RTSA_ZERO32;
            ack_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            global_busy_ff <= nxt_global_busy;
            hold_sel_ff <= nxt_hold_sel;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    assign IRQ = |(irq_stat_ff & irq_mask_ff);

    // Command response: busy and buffer choice latched at command time
    always_comb
    begin
        nxt_state = state_ff;
        nxt_resp_busy = resp_busy_ff;
        nxt_busy = busy_ff;
        nxt_use_b = use_b_ff;
        case (state_ff)
            RTSA_IDLE:
            begin
                if (TX_CMD_VALID)
                begin
                    nxt_state = RTSA_RESP;
                    nxt_resp_busy = busy_now;
                    nxt_busy = busy_now;
                    // Pointer B only counts in ping-pong mode
                    nxt_use_b = next_buf && (mode == `RTSA_MODE_PINGPONG);
                end
            end
            RTSA_RESP:
            begin
                if (MSG_DONE)
                begin
                    nxt_state = RTSA_IDLE;
                    nxt_busy = 1'b0;
                end
            end
            default:
            begin
                nxt_state = RTSA_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_ff <= RTSA_IDLE;
            resp_busy_ff <= 1'b0;
            busy_ff <= 1'b0;
            use_b_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            resp_busy_ff <= nxt_resp_busy;
            busy_ff <= nxt_busy;
            use_b_ff <= nxt_use_b;
        end
    end

    assign RESP_VALID = (state_ff == RTSA_RESP);
    assign RESP_BUSY = resp_busy_ff;
    assign RESP_SEND_DATA = RESP_VALID && !resp_busy_ff;
    assign RESP_USE_PTR_B = use_b_ff;

endmodule : rtsa_ctrl_word

//--- rtsa_bc_model.sv
/*
 Bus controller model: one transmit command, then a completion pulse.
 Assumes the bench raises start for one cycle only while no message is open.
*/
`timescale 1ns/1ps

module rtsa_bc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench control
    input wire logic start,
    input wire logic err,
    input wire logic [2:0] gap,
    // Link
    output logic tx_cmd_valid,
    output logic msg_done,
    output logic msg_error
);
    logic [3:0] cnt_ff;
    logic err_ff;
    // Error line toggles outside completion so a stale level is never trusted
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 4'h0;
            err_ff <= 1'b0;
            tx_cmd_valid <= 1'b0;
            msg_done <= 1'b0;
            msg_error <= 1'b0;
        end
        else
        begin
            tx_cmd_valid <= start;
            msg_done <= cnt_ff == 4'h1;
            msg_error <= (cnt_ff == 4'h1) ? err_ff : !msg_error;
            if (start)
            begin
                cnt_ff <= {1'b0, gap} + 4'h2;
                err_ff <= err;
            end
            else if (cnt_ff != 4'h0)
                cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule : rtsa_bc_model

//--- rtsa_ctrl_word_asserts.sv
/*
 Port checker for rtsa_ctrl_word, bound to every instance.
 Assumes writes use all byte lanes and never overlap a command.
*/
`timescale 1ns/1ps
`include "rtsa_cfg.svh"

module rtsa_ctrl_word_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Register bus
    input wire logic [`RTSA_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Link
    input wire logic SOFT_RESET_COMMAND,
    input wire logic MSG_DONE,
    input wire logic MSG_ERROR,
    input wire logic TX_CMD_VALID,
    input wire logic RESP_VALID,
    input wire logic RESP_BUSY,
    input wire logic RESP_SEND_DATA,
    input wire logic RESP_USE_PTR_B
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);
    logic fb_ff, gb_ff, hold_ff, sel_ff, wr_ok;
    logic nxt_fb, nxt_gb, nxt_hold, nxt_sel;
    logic [1:0] mode_ff, nxt_mode;
    // Mirror of host settings so answers can be tied to them
    always_comb
    begin
        wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
        {nxt_fb, nxt_mode} = {fb_ff, mode_ff};
        nxt_gb = gb_ff;
        nxt_hold = hold_ff;
        nxt_sel = sel_ff;
        if (wr_ok && AVS_ADDRESS == 4'h0)
            {nxt_fb, nxt_mode} = {AVS_WRITEDATA[12], AVS_WRITEDATA[1:0]};
        if (wr_ok && AVS_ADDRESS == 4'h4)
            nxt_gb = AVS_WRITEDATA[0];
        if (wr_ok && AVS_ADDRESS == 4'h8)
            nxt_hold = AVS_WRITEDATA[0];
        // Only ping-pong mode moves the selector
        if (MSG_DONE && mode_ff == 2'h0 && !(RESP_VALID && RESP_BUSY) && !(MSG_ERROR && hold_ff))
            nxt_sel = !sel_ff;
        if (SOFT_RESET_COMMAND)
            nxt_sel = 1'b0;
    end
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            {fb_ff, gb_ff, hold_ff, sel_ff, mode_ff} <= 6'h0;
        else
            {fb_ff, gb_ff, hold_ff, sel_ff, mode_ff} <=
                {nxt_fb, nxt_gb, nxt_hold, nxt_sel, nxt_mode};
    end
    sequence cmd_taken;
        TX_CMD_VALID && !RESP_VALID;
    endsequence
    sequence msg_end;
        RESP_VALID && MSG_DONE;
    endsequence
    busy_answer_a:
        assert property (cmd_taken |=> RESP_VALID && RESP_BUSY == (fb_ff || gb_ff))
        else $error("busy answer wrong");
    busy_no_data_a:
        assert property (RESP_VALID |-> RESP_SEND_DATA == !RESP_BUSY)
        else $error("data sent while busy");
    ptr_select_a:
        assert property (cmd_taken |=> mode_ff != 2'h0 || RESP_USE_PTR_B == sel_ff)
        else $error("wrong pointer chosen");
    other_mode_a:
        assert property (RESP_VALID && mode_ff != 2'h0 |-> !RESP_USE_PTR_B)
        else $error("pointer B outside ping-pong");
    resp_stand_a:
        assert property (RESP_VALID && !MSG_DONE |=> RESP_VALID && $stable(RESP_USE_PTR_B)
            && $stable(RESP_BUSY))
        else $error("answer changed mid message");
    resp_release_a:
        assert property (msg_end |=> !RESP_VALID)
        else $error("answer not released");
    wait_state_a:
        assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("wait state count wrong");
    unmapped_read_a:
        assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
            |-> AVS_READDATA == `RTSA_UNMAPPED)
        else $error("unmapped read value wrong");
endmodule : rtsa_ctrl_word_chk

bind rtsa_ctrl_word rtsa_ctrl_word_chk u_chk (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SOFT_RESET_COMMAND(SOFT_RESET_COMMAND),
    .MSG_DONE(MSG_DONE), .MSG_ERROR(MSG_ERROR), .TX_CMD_VALID(TX_CMD_VALID),
    .RESP_VALID(RESP_VALID), .RESP_BUSY(RESP_BUSY), .RESP_SEND_DATA(RESP_SEND_DATA),
    .RESP_USE_PTR_B(RESP_USE_PTR_B));

//--- test_rt_tx_subaddr_ctrl_word.sv
/*
 Self-checking bench for rtsa_ctrl_word with a bus controller model.
 Assumes the package, design, model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "rtsa_cfg.svh"

module test_rt_tx_subaddr_ctrl_word;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic soft_reset_command = 1'b0;
    logic start = 1'b0;
    logic err = 1'b0;
    logic [2:0] gap = 3'h0;
    logic [31:0] rdat;
    logic wreq, txv, done, merr, rv, rb, rs, rp, irq, rv_q;
    logic fb, gb, hold, sel, acc;
    logic [1:0] mode;
    logic [63:0] e;
    logic [63:0] rd_q[$];
    logic [2:0] rsp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'h3E569CAD;

    rtsa_ctrl_word uut (
        .SYS_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .SOFT_RESET_COMMAND(soft_reset_command), .TX_CMD_VALID(txv), .MSG_DONE(done), .MSG_ERROR(merr),
        .RESP_VALID(rv), .RESP_BUSY(rb), .RESP_SEND_DATA(rs), .RESP_USE_PTR_B(rp), .IRQ(irq));
    rtsa_bc_model bc (
        .clk(clk), .rst_n(rst_n), .start(start), .err(err), .gap(gap),
        .tx_cmd_valid(txv), .msg_done(done), .msg_error(merr));

    always #20 clk = ~clk;

    task automatic results;
        $display("Checks %0d, errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Results are checked where they appear, against notes queued by the driver
    always @(posedge clk)
    begin
        if (rd === 1'b1 && wreq === 1'b0 && rd_q.size() > 0)
        begin
            e = rd_q.pop_front();
            chk(rdat & e[63:32], e[31:0]);
        end
        if (rv === 1'b1 && rv_q !== 1'b1 && rsp_q.size() > 0)
            chk({29'h0, rb, rs, rp}, {29'h0, rsp_q.pop_front()});
        rv_q <= rv;
    end

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rdx(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
        rd_q.push_back({m, x & m});
        bus(1'b0, a, 32'h0);
    endtask : rdx

    task automatic rctl;
        rdx(4'h0, 32'h1C03, {19'h0, fb, acc, sel, 8'h0, mode});
        acc = 1'b0;
    endtask : rctl

    // Ones aimed at the read-only bits must be ignored
    task automatic wctl(input logic f, input logic [1:0] m);
        fb = f;
        mode = m;
        bus(1'b1, 4'h0, {19'h0, f, 2'h3, 8'h0, m});
    endtask : wctl

    task automatic msg(input logic x);
        logic b;
        b = fb || gb;
        rsp_q.push_back({b, !b, mode == 2'h0 && sel});
        err <= x;
        gap <= 3'($random(seed));
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        while (rv !== 1'b0) @(posedge clk);
        acc = 1'b1;
        if (!b && mode == 2'h0 && !(x && hold))
            sel = !sel;
    endtask : msg

    task automatic irqchk(input logic x);
        @(posedge clk);
        chk({31'h0, irq}, {31'h0, x});
    endtask : irqchk

    task automatic hard_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        {fb, gb, hold, sel, acc, mode} = 7'h0;
    endtask : hard_reset

    initial
    begin
        #400000;
        fail_count++;
        results();
    end

    initial
    begin
        hard_reset();
        rctl();
        rdx(4'h2, 32'hFFFFFFFF, `RTSA_UNMAPPED);
        bus(1'b1, 4'h6, $random(seed));
        wctl(1'b0, `RTSA_MODE_PINGPONG);
        for (int i = 0; i < 5; i++)
        begin
            msg(1'b0);
            rctl();
            rctl();
        end
        hold = 1'b1;
        bus(1'b1, 4'h8, 32'h1);
        msg(1'b1);
        hold = 1'b0;
        bus(1'b1, 4'h8, 32'h0);
        msg(1'b1);
        wctl(1'b1, `RTSA_MODE_PINGPONG);
        msg(1'($random(seed)));
        rctl();
        wctl(1'b0, `RTSA_MODE_PINGPONG);
        gb = 1'b1;
        bus(1'b1, 4'h4, 32'h1);
        msg(1'b0);
        gb = 1'b0;
        bus(1'b1, 4'h4, 32'h0);
        if (sel == 1'b0)
            msg(1'b0);
        // Selector is 1 here, so a stray pointer B would show
        for (int m = 1; m < 4; m++)
        begin
            wctl(m == 1, 2'(m));
            msg(1'b0);
        end
        // Good messages in other modes must leave the selector alone
        rctl();
        wctl(1'b0, `RTSA_MODE_PINGPONG);
        soft_reset_command <= 1'b1;
        @(posedge clk);
        soft_reset_command <= 1'b0;
        @(posedge clk);
        {sel, acc} = 2'h0;
        rctl();
        bus(1'b1, 4'hC, 32'h100);
        irqchk(1'b0);
        msg(1'b0);
        irqchk(1'b1);
        bus(1'b1, 4'hC, 32'h101);
        irqchk(1'b0);
        bus(1'b1, 4'hC, 32'h0);
        msg(1'b0);
        irqchk(1'b0);
        rdx(4'hC, 32'h707, 32'h3);
        hard_reset();
        rctl();
        msg(1'b0);
        results();
    end
endmodule : test_rt_tx_subaddr_ctrl_word
